// file: dv/tb_scs_clock_switch.sv
// Purpose: self-checking bench for the system clock source switch
// Assumes: axi4-lite at 250 MHz, source clocks made from a free counter
// Notes:   an integer register model predicts the oscillator control reads
`timescale 1ns/1ns
module tb_scs_clock_switch;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp, active_src;
    logic        awready, wready, bvalid, arready, rvalid, clk_out;
    logic        cfg_ld, dflt, mult, slp, p_clk, p_rdy, t_clk, t_rdy;
    logic        f_clk, f_stb, s_clk, switching, sleep_req, idle_req, mon;
    logic        sw_seen, pc, pf;
    logic [2:0]  postscale;
    logic [5:0]  trim;
    logic [7:0]  cnt;
    logic [15:0] lfsr_q;
    int          failures, samples_checked, osc_m, v, cr, fr;

    scs_clock_switch i_scs_clock_switch (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .config_loaded(cfg_ld),
        .default_source_config(dflt), .multiplied_mode(mult),
        .sleep_exec(slp), .primary_clk(p_clk), .primary_ready(p_rdy),
        .timer_osc_clk(t_clk), .timer_osc_ready(t_rdy), .fast_rc_clk(f_clk),
        .fast_rc_stable(f_stb), .slow_rc_clk(s_clk), .clk_out(clk_out),
        .active_src(active_src), .switching(switching),
        .sleep_req(sleep_req), .idle_req(idle_req),
        .fast_rc_postscale(postscale), .fast_rc_trim(trim),
        .multiplier_on(mon));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // source clocks at slower power-of-two rates from one counter
    always @(posedge aclk) begin
        cnt   <= cnt + 8'h01;
        p_clk <= cnt[2];
        t_clk <= cnt[4];
        f_clk <= cnt[1];
        s_clk <= cnt[3];
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic stop_test();
        if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bail();
        failures++;
        stop_test();
    endtask : bail

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n <= 100; n++) begin
            if (n == 100) bail();
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n <= 100; n++) begin
            if (n == 100) bail();
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd = rdata; resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wr_osc(input int d);
        osc_m = d & 32'hF3;
        axi_wr(scs_pkg::ADDR_OSC_CONTROL, d);
    endtask : wr_osc

    task automatic wait_src(input logic [1:0] s);
        sw_seen = 1'b0;
        for (int n = 0; n <= 300; n++) begin
            if (n == 300) bail();
            @(posedge aclk);
            if (switching === 1'b1) sw_seen = 1'b1;
            if (active_src === s && switching === 1'b0) break;
        end
    endtask : wait_src

    task automatic do_reset(input logic d);
        @(posedge aclk);
        aresetn <= 1'b0; cfg_ld <= 1'b0; dflt <= d;
        mult <= d;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        osc_m = 32'h40;
    endtask : do_reset

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, slp, cfg_ld} = 7'h00;
        {awaddr, araddr, wdata, cnt, mult, dflt} = 50'h0;
        {p_rdy, t_rdy, f_stb} = 3'h7;
        wstrb = 4'h1;
        lfsr_q = 16'h0AB8;
        aresetn = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (3) @(posedge aclk);
        do_reset(1'b0);
        repeat (3) @(posedge aclk);
        chk(active_src, 32'h3);
        cfg_ld <= 1'b1;
        wait_src(2'h2);
        chk(postscale, 32'h4);
        axi_rd(scs_pkg::ADDR_OSC_CONTROL);
        chk(rd & 32'hF3, osc_m);
        axi_rd(scs_pkg::ADDR_TUNING);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr(lfsr_q);
            v = lfsr_q[7:0];
            axi_wr(scs_pkg::ADDR_TUNING, v);
            axi_rd(scs_pkg::ADDR_TUNING);
            chk(rd, v & 32'hBF);
            chk(trim, v & 32'h3F);
            chk(mon, 32'h0);
        end
        for (int f = 0; f < 8; f++) begin
            wr_osc((f << 4) | 3);
            @(posedge aclk);
            chk(postscale, f);
        end
        axi_wr(scs_pkg::ADDR_TIMER_CTRL, 32'h08);
        wr_osc(32'h71);
        wait_src(2'h1);
        chk(sw_seen, 32'h1);
        axi_rd(scs_pkg::ADDR_TIMER_CTRL);
        chk(rd, 32'h48);
        p_rdy <= 1'b0;
        wr_osc(32'h72);
        repeat (100) @(posedge aclk);
        chk({switching, clk_out}, 32'h2);
        p_rdy <= 1'b1;
        wait_src(2'h0);
        axi_rd(scs_pkg::ADDR_OSC_CONTROL);
        chk((rd >> 3) & 1, 32'h1);
        wr_osc(32'hF3);
        wait_src(2'h2);
        {pc, pf} = {clk_out, f_clk};
        cr = 0;
        fr = 0;
        repeat (32) begin
            @(posedge aclk);
            cr += int'(clk_out & ~pc);
            fr += int'(f_clk & ~pf);
            {pc, pf} = {clk_out, f_clk};
        end
        chk(cr, fr);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) wr_osc(32'h73);
            @(posedge aclk);
            slp <= 1'b1;
            @(posedge aclk);
            slp <= 1'b0;
            @(posedge aclk);
            chk({idle_req, sleep_req}, k ? 32'h1 : 32'h2);
        end
        axi_wr(4'h2, 32'h00);
        chk(resp, 32'h2);
        axi_rd(4'h2);
        chk(resp, 32'h2);
        axi_rd(scs_pkg::ADDR_OSC_CONTROL);
        chk(rd & 32'hF3, osc_m);
        do_reset(1'b1);
        axi_rd(scs_pkg::ADDR_OSC_CONTROL);
        chk(rd & 32'hF3, osc_m);
        cfg_ld <= 1'b1;
        wait_src(2'h0);
        axi_wr(scs_pkg::ADDR_TUNING, 32'hC5);
        axi_rd(scs_pkg::ADDR_TUNING);
        chk(rd, 32'hC5);
        chk(mon, 32'h1);
        stop_test();
    end
endmodule : tb_scs_clock_switch

// file: rtl/scs_clock_switch.sv
// Purpose: selects the system clock source and switches it glitch-free
// Assumes: source clocks are slow levels sampled on aclk
// Notes:   clk_out is the gated, muxed system clock as a level
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns

// What this block does
// RULE1: frequency select write retunes internal clock at once while it runs
// RULE2: clock select write starts a source switch at once
// RULE3: low-freq bit 1 divides fast rc by 256, else slow rc
// RULE4: multiplier enable exists only in multiplied modes, else reads 0
// RULE5: trim field is signed offset, zero is centre
// RULE6: two-bit select picks primary, secondary or internal after a pause
// RULE7: startup status set for primary, timer running for secondary
// RULE8: idle enable decides idle or sleep on the sleep instruction
// RULE9: secondary select on sleep ignored unless timer osc enabled
// RULE10: software should have timer osc stable before sleeping
// RULE11: clock select cleared to 00 on every reset
// RULE12: select 00 means primary if config bit 1, else internal
// RULE13: internal default runs fast rc at 1 MHz setting
// RULE14: power-up clocks from slow rc until configuration is loaded
// RULE15: switch pauses two old edges plus three to four new edges
// RULE16: select 11 internal, 10 primary, 01 secondary
// RULE17: frequency select 111 is 8 MHz, 100 is 1 MHz, 000 is 31 kHz
// RULE18: old clock held until new source stable, no runt pulse
module scs_clock_switch #(
    parameter int TRIM_W = 6
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        config_loaded,
    input  wire logic        default_source_config,
    input  wire logic        multiplied_mode,
    input  wire logic        sleep_exec,
    input  wire logic        primary_clk,
    input  wire logic        primary_ready,
    input  wire logic        timer_osc_clk,
    input  wire logic        timer_osc_ready,
    input  wire logic        fast_rc_clk,
    input  wire logic        fast_rc_stable,
    input  wire logic        slow_rc_clk,
    output logic             clk_out,
    output logic [1:0]       active_src,
    output logic             switching,
    output logic             sleep_req,
    output logic             idle_req,
    output logic [2:0]       fast_rc_postscale,
    output logic [TRIM_W-1:0] fast_rc_trim,
    output logic             multiplier_on
);

    // ----------------------------------------------------------------
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ----------------------------------------------------------------
    localparam int NP = 8;
    logic [NP-1:0] pin_in;
    logic [NP-1:0] s1_q, s2_q, s3_q, pin_q;
    assign pin_in = {primary_clk, primary_ready, timer_osc_clk,
                     timer_osc_ready, fast_rc_clk, fast_rc_stable,
                     slow_rc_clk, 1'b0};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            pin_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
        end
    end
    wire p_clk   = pin_q[7];
    wire p_rdy   = pin_q[6];
    wire t_clk   = pin_q[5];
    wire t_rdy   = pin_q[4];
    wire f_clk   = pin_q[3];
    wire f_stab  = pin_q[2];
    wire s_clk   = pin_q[1];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic             idle_en_q;
    logic [2:0]       freq_sel_q;
    logic [1:0]       sel_q;
    logic             lf_src_q, mult_q, t_osc_en_q;
    logic [TRIM_W-1:0] trim_q;
    logic             cfg_done_q, def_cfg_q, mult_mode_q;

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    logic       aw_hold_q, w_hold_q;
    logic [3:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_hold_q | aw_take;
    wire have_w  = w_hold_q | w_take;
    wire do_wr   = have_aw & have_w & ~s_axi_bvalid;
    wire [3:0] wa  = aw_hold_q ? aw_q : s_axi_awaddr;
    wire [31:0] wd = w_hold_q ? wd_q : s_axi_wdata;
    wire [3:0] wsb = w_hold_q ? ws_q : s_axi_wstrb;
    wire wr_ok = (wa == scs_pkg::ADDR_OSC_CONTROL) |
                 (wa == scs_pkg::ADDR_TUNING) |
                 (wa == scs_pkg::ADDR_TIMER_CTRL) |
                 (wa == scs_pkg::ADDR_STATUS);
    wire wr_byte0 = do_wr & wsb[0];
    wire wr_osc  = wr_byte0 & (wa == scs_pkg::ADDR_OSC_CONTROL);
    wire wr_tune = wr_byte0 & (wa == scs_pkg::ADDR_TUNING);
    wire wr_tmr  = wr_byte0 & (wa == scs_pkg::ADDR_TIMER_CTRL);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_q          <= '0;
            wd_q          <= '0;
            ws_q          <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            if (aw_take) aw_q <= s_axi_awaddr;
            if (w_take) begin
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            aw_hold_q <= have_aw & ~do_wr;
            w_hold_q  <= have_w & ~do_wr;
            s_axi_awready <= ~have_aw & ~s_axi_awready;
            s_axi_wready  <= ~have_w & ~s_axi_wready;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read path: status bits are live state
    logic [1:0] src_q;
    logic       startup_timeout_status_q, trun_q;
    wire [7:0] osc_rd = {idle_en_q, freq_sel_q, startup_timeout_status_q, f_stab, sel_q};
    wire [7:0] tune_rd = {lf_src_q, mult_q & mult_mode_q, // see RULE4
                          6'(trim_q)};
    wire [7:0] tmr_rd = {1'b0, trun_q, 2'h0, t_osc_en_q, 3'h0};
    wire [7:0] st_rd  = {5'h0, switching, src_q};
    wire [7:0] rd_mux =
        (s_axi_araddr == scs_pkg::ADDR_OSC_CONTROL) ? osc_rd :
        (s_axi_araddr == scs_pkg::ADDR_TUNING)      ? tune_rd :
        (s_axi_araddr == scs_pkg::ADDR_TIMER_CTRL)  ? tmr_rd : st_rd;
    wire rd_ok = (s_axi_araddr[1:0] == 2'h0);
    wire ar_take = s_axi_arvalid & s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? {24'h0, rd_mux} : 32'h0;
                s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_en_q  <= 1'b0;
            freq_sel_q <= scs_pkg::FREQ_RESET;        // see RULE13
            sel_q      <= scs_pkg::SEL_RESET;         // see RULE11
            lf_src_q   <= 1'b0;
            mult_q     <= 1'b0;
            trim_q     <= '0;
            t_osc_en_q <= 1'b0;
            cfg_done_q <= 1'b0;
            def_cfg_q  <= 1'b0;
            mult_mode_q <= 1'b0;
        end else begin
            if (!cfg_done_q && config_loaded) begin  // see RULE14
                cfg_done_q  <= 1'b1;
                def_cfg_q   <= default_source_config;
                mult_mode_q <= multiplied_mode;
            end
            if (wr_osc) begin
                idle_en_q  <= wd[scs_pkg::IDLE_BIT];
                freq_sel_q <= wd[scs_pkg::FREQ_LSB +: 3];   // see RULE1
                sel_q      <= wd[scs_pkg::SEL_LSB +: 2];    // see RULE2
            end
            if (wr_tune) begin
                lf_src_q <= wd[scs_pkg::LFSRC_BIT];
                mult_q   <= wd[scs_pkg::MULT_BIT] & mult_mode_q; // see RULE4
                trim_q   <= wd[TRIM_W-1:0];                 // see RULE5
            end
            if (wr_tmr) t_osc_en_q <= wd[scs_pkg::T_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // source decode
    // ----------------------------------------------------------------
    function automatic logic [1:0] decode_sel(input logic [1:0] s,
                                              input logic d,
                                              input logic lf);
        logic [1:0] low_freq_source_select;
        low_freq_source_select = lf ? scs_pkg::SRC_FAST_RC : scs_pkg::SRC_SLOW_RC;
        unique case (s)                                    // see RULE16
            scs_pkg::SEL_INTERNAL:  decode_sel = scs_pkg::SRC_FAST_RC;
            scs_pkg::SEL_PRIMARY:   decode_sel = scs_pkg::SRC_PRIMARY;
            scs_pkg::SEL_SECONDARY: decode_sel = scs_pkg::SRC_SECONDARY;
            default: decode_sel = d ? scs_pkg::SRC_PRIMARY   // see RULE12
                                    : scs_pkg::SRC_FAST_RC;
        endcase
        if (decode_sel == scs_pkg::SRC_FAST_RC && lf == 1'b0)
            decode_sel = low_freq_source_select;
    endfunction : decode_sel

    // 000 means low-frequency: fast rc /256 or slow rc
    wire lf_sel = (freq_sel_q == 3'h0);
    wire [1:0] want_raw = !cfg_done_q ? scs_pkg::SRC_SLOW_RC  // see RULE14
        : decode_sel(sel_q, def_cfg_q, ~lf_sel | lf_src_q);   // see RULE3
    // secondary on sleep needs the timer oscillator enabled
    wire sec_block = sleep_exec & ~t_osc_en_q &
                     (want_raw == scs_pkg::SRC_SECONDARY);    // see RULE9
    wire [1:0] want = sec_block ? src_q : want_raw;

    // fast rc: divide by 256 for low frequency, postscale otherwise
    logic [7:0] lf_cnt_q;
    logic       f_prev_q, lf_clk_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_cnt_q <= '0;
            f_prev_q <= 1'b0;
            lf_clk_q <= 1'b0;
        end else begin
            f_prev_q <= f_clk;
            if (f_clk & ~f_prev_q) begin
                lf_cnt_q <= lf_cnt_q + 8'h01;
                // toggle every 128 edges: a full period is 256 edges
                if (lf_cnt_q[6:0] == scs_pkg::LF_DIV_MAX[6:0])
                    lf_clk_q <= ~lf_clk_q;                  // see RULE3
            end
        end
    end
    wire fast_lvl = (lf_sel ? lf_clk_q : f_clk);

    function automatic logic pick(input logic [1:0] s, input logic p,
                                  input logic t, input logic f,
                                  input logic r);
        unique case (s)
            scs_pkg::SRC_PRIMARY:   pick = p;
            scs_pkg::SRC_SECONDARY: pick = t;
            scs_pkg::SRC_FAST_RC:   pick = f;
            default:                pick = r;
        endcase
    endfunction : pick

    // new side follows the latched target, not a select changed mid-switch
    logic [1:0] tgt_q;
    wire new_rdy = pick(tgt_q, p_rdy, t_rdy, f_stab, 1'b1);
    wire old_lvl = pick(src_q, p_clk, t_clk, fast_lvl, s_clk);
    wire new_lvl = pick(tgt_q, p_clk, t_clk, fast_lvl, s_clk);

    // ----------------------------------------------------------------
    // glitch-free switch: old falls twice, then new rises three times
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_OLD  = 3'b010,
        ST_NEW  = 3'b100
    } scs_state_t;
    scs_state_t st_q;
    logic [2:0] edge_q;
    logic       old_prev_q, new_prev_q;
    wire old_fall = old_prev_q & ~old_lvl;
    wire new_rise = ~new_prev_q & new_lvl;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q       <= ST_RUN;
            edge_q     <= '0;
            src_q      <= scs_pkg::SRC_SLOW_RC;
            tgt_q      <= scs_pkg::SRC_SLOW_RC;
            old_prev_q <= 1'b0;
            new_prev_q <= 1'b0;
            clk_out    <= 1'b0;
        end else begin
            old_prev_q <= old_lvl;
            new_prev_q <= new_lvl;
            unique case (st_q)
                ST_RUN: begin
                    clk_out <= old_lvl;
                    if (want != src_q) begin             // see RULE2
                        st_q   <= ST_OLD;
                        tgt_q  <= want;
                        edge_q <= '0;
                    end
                end
                ST_OLD: begin
                    if (old_fall) begin                  // see RULE15
                        clk_out <= 1'b0;
                        if (edge_q == scs_pkg::OLD_EDGES - 3'h1) begin
                            st_q   <= ST_NEW;
                            edge_q <= '0;
                        end else begin
                            edge_q <= edge_q + 3'h1;
                        end
                    end else if (edge_q == 3'h0) begin
                        clk_out <= old_lvl;
                    end
                end
                ST_NEW: begin
                    clk_out <= 1'b0;
                    // hold low until new source is stable  see RULE18
                    if (new_rise && new_rdy) begin
                        if (edge_q == scs_pkg::NEW_EDGES - 3'h1) begin
                            st_q  <= ST_RUN;
                            src_q <= tgt_q;              // see RULE6
                        end else begin
                            edge_q <= edge_q + 3'h1;
                        end
                    end
                end
                default: st_q <= ST_RUN;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // status and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            startup_timeout_status_q            <= 1'b0;
            trun_q            <= 1'b0;
            active_src        <= scs_pkg::SRC_SLOW_RC;
            switching         <= 1'b0;
            sleep_req         <= 1'b0;
            idle_req          <= 1'b0;
            fast_rc_postscale <= scs_pkg::FREQ_RESET;
            fast_rc_trim      <= '0;
            multiplier_on     <= 1'b0;
        end else begin
            // only one of the two is ever set  see RULE7
            startup_timeout_status_q <= (src_q == scs_pkg::SRC_PRIMARY) & p_rdy;
            trun_q <= (src_q == scs_pkg::SRC_SECONDARY);
            active_src <= src_q;
            switching  <= (st_q != ST_RUN);
            sleep_req  <= sleep_exec & ~idle_en_q;        // see RULE8
            idle_req   <= sleep_exec & idle_en_q;         // see RULE8
            fast_rc_postscale <= freq_sel_q;              // see RULE17
            fast_rc_trim  <= trim_q;                      // see RULE5
            multiplier_on <= mult_q & mult_mode_q;        // see RULE4
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_status_exclusive: assert property ( // see RULE7
        @(posedge aclk) disable iff (!aresetn) !(startup_timeout_status_q && trun_q))
        else $error("startup and timer running both set");
    a_reset_select: assert property ( // see RULE11
        @(posedge aclk) !aresetn |=> (sel_q == 2'h0))
        else $error("clock select not cleared by reset");
    a_mult_reads_zero: assert property ( // see RULE4
        @(posedge aclk) disable iff (!aresetn)
        !mult_mode_q |-> !multiplier_on)
        else $error("multiplier on outside multiplied mode");
    a_switch_starts: assert property ( // see RULE2
        @(posedge aclk) disable iff (!aresetn)
        (st_q == ST_RUN && want != src_q) |=> (st_q == ST_OLD))
        else $error("switch did not start at once");
    a_new_held_low: assert property ( // see RULE18
        @(posedge aclk) disable iff (!aresetn)
        (st_q == ST_NEW) |=> !clk_out)
        else $error("clock not held low while waiting new source");
    a_slow_before_cfg: assert property ( // see RULE14
        @(posedge aclk) disable iff (!aresetn)
        !cfg_done_q |-> (want == scs_pkg::SRC_SLOW_RC))
        else $error("not on slow rc before configuration");
    a_freq_follows: assert property ( // see RULE1
        @(posedge aclk) disable iff (!aresetn)
        wr_osc |=> ##1 (fast_rc_postscale == $past(wd[6:4], 2)))
        else $error("frequency select not applied");
    a_sleep_idle: assert property ( // see RULE8
        @(posedge aclk) disable iff (!aresetn)
        sleep_exec |=> (idle_req == $past(idle_en_q))
                       && (sleep_req != idle_req))
        else $error("sleep versus idle decision wrong");

endmodule : scs_clock_switch

// file: rtl/scs_pkg.sv
// Purpose: constants and types for the system clock source switch
// Assumes: one 250 MHz bus clock, axi4-lite register access
// Notes:   source clocks arrive as sampled levels, not as clock ports
package scs_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_OSC_CONTROL  = 4'h0;
    localparam logic [3:0] ADDR_TUNING       = 4'h4;
    localparam logic [3:0] ADDR_TIMER_CTRL   = 4'h8;
    localparam logic [3:0] ADDR_STATUS       = 4'hC;

    // osc_control_reg fields
    localparam int IDLE_BIT   = 7;
    localparam int FREQ_LSB   = 4;
    localparam int STARTUP_TIMEOUT_STATUS_BIT   = 3;
    localparam int STABLE_BIT = 2;
    localparam int SEL_LSB    = 0;
    // internal_osc_tuning fields
    localparam int LFSRC_BIT  = 7;
    localparam int MULT_BIT   = 6;
    // timer_osc_control_reg fields
    localparam int T_RUN_BIT  = 6;
    localparam int T_EN_BIT   = 3;

    // reset values
    localparam logic [2:0] FREQ_RESET   = 3'h4;
    localparam logic [1:0] SEL_RESET    = 2'h0;
    localparam logic [7:0] TUNING_RESET = 8'h00;

    // clock select encodings
    localparam logic [1:0] SEL_INTERNAL  = 2'h3;
    localparam logic [1:0] SEL_PRIMARY   = 2'h2;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;

    // switch pause: old-source and new-source edges
    localparam logic [2:0] OLD_EDGES = 3'h2;
    localparam logic [2:0] NEW_EDGES = 3'h3;
    // 8 MHz fast rc divided by 256 for the low-frequency clock
    localparam logic [7:0] LF_DIV_MAX = 8'hFF;

    typedef enum logic [1:0] {
        SRC_PRIMARY   = 2'h0,
        SRC_SECONDARY = 2'h1,
        SRC_FAST_RC   = 2'h2,
        SRC_SLOW_RC   = 2'h3
    } scs_src_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] data;
    } scs_wreq_t;

endpackage : scs_pkg
